// File: rtl/lo_cfg_pkg.sv
// Purpose: shared constants and carriers for the oscillator path configuration bank
// Assumes: 32-bit APB data, 16-bit registers in the low half of each word
// Notes:   printed offsets are word indices; byte address is four times the index
package lo_cfg_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam int          REG_W            = 16;
   localparam int          ADDR_W           = 12;
   localparam logic [7:0]  IDX_CHAIN        = 8'h4F;
   localparam logic [7:0]  IDX_SYNC         = 8'h50;
   localparam logic [7:0]  IDX_MODE         = 8'h51;
   localparam logic [1:0]  SEL_CHAIN        = 2'h0;
   localparam logic [1:0]  SEL_SYNC         = 2'h1;
   localparam logic [1:0]  SEL_MODE         = 2'h2;
   localparam logic [1:0]  SEL_NONE         = 2'h3;
   // writable bits per register; reserved bits stay zero
   localparam logic [15:0] MASK_CHAIN       = 16'h7047;
   localparam logic [15:0] MASK_SYNC        = 16'h0E3F;
   localparam logic [15:0] MASK_MODE        = 16'h0FF7;
   localparam logic [15:0] RST_CHAIN        = 16'h7000;
   localparam logic [15:0] RST_SYNC         = 16'h000A;
   localparam logic [15:0] RST_MODE         = 16'h0000;
   localparam logic [5:0]  MUX_DIV2         = 6'h09;
   localparam logic [1:0]  SRC_EXT          = 2'h3;

   // ****************************************************************
   // decoded controls toward the analog blocks
   // ****************************************************************
   typedef struct packed {
      logic [2:0] osc_path_section_enables;
      logic       if_amp_input_pullup_enable;
      logic       low_noise_amp_powerdown;
      logic       signal_chain_master_reset;
      logic       signal_chain_master_powerdown;
      logic       sync_loop_close;
      logic       sync_second_driver_enable;
      logic       sync_first_driver_enable;
      logic [5:0] osc_mux_driver_setup;
      logic [3:0] polyphase_path_params;
      logic [1:0] sequencer_clock_driver_select;
      logic [1:0] quadrature_driver_setup;
      logic [1:0] sequencer_clock_driver_enables;
      logic       sequencer_clock_source;
   } lo_ctrl_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACCESS = 3'b010,
      ST_DONE   = 3'b100
   } apb_state_t;
endpackage

// File: rtl/cfg_word_reg.sv
// Purpose: one masked 16-bit configuration word with registered readback
// Assumes: write strobe is a one-cycle pulse from the bus slave
// Notes:   reserved bits never store, so they read back as zero
`timescale 1ns/1ps
module cfg_word_reg #(
   parameter logic [15:0] MASK  = 16'hFFFF,
   parameter logic [15:0] RESET = 16'h0000
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        wr,
   input  wire logic [15:0] wdata,
   output logic      [15:0] value
);
   // ****************************************************************
   // storage
   // ****************************************************************
   // masking on the way in keeps reserved bits at zero forever
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= RESET & MASK;
      end else if (clk_en && wr) begin
         value <= wdata & MASK;
      end
   end
endmodule

// File: rtl/lo_path_mode_config_regs.sv
// Purpose: APB slave holding three oscillator path and mode configuration words
// Assumes: single clock pclk; all inputs synchronous to it
// Notes:   two wait states per transfer; unmapped reads return zero, no error
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module lo_path_mode_config_regs
   import lo_cfg_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output lo_ctrl_t               ctrl,
   output logic                   mode_reserved_code
);
   // ****************************************************************
   // address decode
   // ****************************************************************
   apb_state_t  state;
   logic [1:0]  sel;
   logic [15:0] chain_q;
   logic [15:0] sync_q;
   logic [15:0] mode_q;
   logic [15:0] next_wdata;
   logic        wr_chain;
   logic        wr_sync;
   logic        wr_mode;
   logic        do_wr;
   logic [15:0] cur_word;
   logic        first_cycle;

   // word index compare; byte address is four times the printed offset
   always_comb begin
      sel = SEL_NONE;
      if (paddr[1:0] == 2'h0) begin
         case (paddr[ADDR_W-1:2])
            10'(IDX_CHAIN): sel = SEL_CHAIN;
            10'(IDX_SYNC):  sel = SEL_SYNC;
            10'(IDX_MODE):  sel = SEL_MODE;
            default:        sel = SEL_NONE;
         endcase
      end
   end

   // addressed word, shared by the byte merge and the read path
   assign cur_word = current_word(sel);

   // byte lanes 0 and 1 carry the register; lanes 2-3 are ignored
   always_comb begin
      next_wdata       = 16'h0000;
      next_wdata[7:0]  = pstrb[0] ? pwdata[7:0] : cur_word[7:0];
      next_wdata[15:8] = pstrb[1] ? pwdata[15:8] : cur_word[15:8];
   end

   function automatic logic [15:0] current_word(input logic [1:0] s);
      case (s)
         SEL_CHAIN: current_word = chain_q;
         SEL_SYNC:  current_word = sync_q;
         SEL_MODE:  current_word = mode_q;
         default:   current_word = 16'h0000;
      endcase
   endfunction

   // ****************************************************************
   // transfer sequencing
   // ****************************************************************
   // the extra wait state gives registered read data a full cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else if (clk_en) begin
         case (state)
            ST_IDLE:   state <= (psel && penable) ? ST_ACCESS : ST_IDLE;
            ST_ACCESS: state <= ST_DONE;
            ST_DONE:   state <= ST_IDLE;
            default:   state <= ST_IDLE;
         endcase
      end
   end

   assign do_wr    = (state == ST_ACCESS) && psel && penable && pwrite;
   assign wr_chain = do_wr && (sel == SEL_CHAIN);
   assign wr_sync  = do_wr && (sel == SEL_SYNC);
   assign wr_mode  = do_wr && (sel == SEL_MODE);

   // pready rises one cycle after access phase entry, stays one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= (state == ST_ACCESS);
         pslverr <= 1'b0;
      end
   end

   // read data loaded with pready; zero outside a read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (state == ST_ACCESS && !pwrite) begin
            prdata <= {16'h0000, cur_word};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ****************************************************************
   // register words
   // ****************************************************************
   // chain word with path enables reset
   cfg_word_reg #(.MASK(MASK_CHAIN), .RESET(RST_CHAIN)) u_chain (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .wr      (wr_chain),
      .wdata   (next_wdata),
      .value   (chain_q)
   );

   cfg_word_reg #(.MASK(MASK_SYNC), .RESET(RST_SYNC)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .wr      (wr_sync),
      .wdata   (next_wdata),
      .value   (sync_q)
   );

   cfg_word_reg #(.MASK(MASK_MODE), .RESET(RST_MODE)) u_mode (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .wr      (wr_mode),
      .wdata   (next_wdata),
      .value   (mode_q)
   );

   // ****************************************************************
   // control outputs
   // ****************************************************************
   // fields registered once more so outputs come straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= '0;
         ctrl.osc_path_section_enables <= RST_CHAIN[14:12];
         ctrl.osc_mux_driver_setup     <= RST_SYNC[5:0];
      end else if (clk_en) begin
         ctrl.osc_path_section_enables       <= chain_q[14:12];
         ctrl.if_amp_input_pullup_enable     <= chain_q[6];
         ctrl.low_noise_amp_powerdown        <= chain_q[2];
         ctrl.signal_chain_master_powerdown  <= chain_q[0];
         // chain held in reset while set
         ctrl.signal_chain_master_reset      <= chain_q[1];
         ctrl.sync_loop_close                <= sync_q[11];
         ctrl.sync_second_driver_enable      <= sync_q[10];
         ctrl.sync_first_driver_enable       <= sync_q[9];
         ctrl.osc_mux_driver_setup           <= sync_q[5:0];
         ctrl.polyphase_path_params          <= mode_q[11:8];
         ctrl.sequencer_clock_driver_select  <= mode_q[7:6];
         ctrl.quadrature_driver_setup        <= mode_q[5:4];
         ctrl.sequencer_clock_driver_enables <= mode_q[2:1];
         ctrl.sequencer_clock_source         <= mode_q[0];
      end
   end

   // flags a reserved code in the driver select or quadrature mode field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reserved_code <= 1'b0;
      end else if (clk_en) begin
         // codes 1 and 2 reserved; code 2 reserved
         mode_reserved_code <= (mode_q[7:6] == 2'h1) || (mode_q[7:6] == 2'h2)
                               || (mode_q[5:4] == 2'h2);
      end
   end

   // marks the first enabled cycle after reset so reset images can be checked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_cycle <= 1'b1;
      end else if (clk_en) begin
         first_cycle <= 1'b0;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chain_write_ok_a: assert property ((wr_chain && clk_en && pstrb == 4'hF) |=>
      chain_q == ($past(pwdata[15:0]) & MASK_CHAIN)) else $error("chain write lost");
   pullup_follows_a: assert property (clk_en |=>
      ctrl.if_amp_input_pullup_enable == $past(chain_q[6]))
      else $error("pull-up not following");
   powerdown_map_a: assert property (clk_en |=> ctrl.low_noise_amp_powerdown == $past(chain_q[2])
      && ctrl.signal_chain_master_powerdown == $past(chain_q[0]))
      else $error("powerdown mismatch");
   chain_reset_a: assert property (clk_en |=>
      ctrl.signal_chain_master_reset == $past(chain_q[1])) else $error("reset bit lost");
   sync_bits_a: assert property (clk_en |=> ctrl.sync_loop_close == $past(sync_q[11])
      && ctrl.sync_second_driver_enable == $past(sync_q[10])
      && ctrl.sync_first_driver_enable == $past(sync_q[9])) else $error("sync bits");
   drv2_store_a: assert property ((wr_sync && clk_en && pstrb[1]) |=>
      sync_q[10] == $past(pwdata[10])) else $error("driver two write");
   drv1_store_a: assert property ((wr_sync && clk_en && pstrb[1]) |=>
      sync_q[9] == $past(pwdata[9])) else $error("driver one write");
   mux_map_a: assert property (clk_en |=>
      ctrl.osc_mux_driver_setup == $past(sync_q[5:0])) else $error("mux mismatch");
   mode_fields_a: assert property (clk_en |=> ctrl.polyphase_path_params == $past(mode_q[11:8])
      && ctrl.sequencer_clock_driver_select == $past(mode_q[7:6])
      && ctrl.quadrature_driver_setup == $past(mode_q[5:4])) else $error("mode fields");
   reserved_flag_a: assert property (clk_en |=> mode_reserved_code ==
      ($past(mode_q[7:6]) inside {2'h1, 2'h2} || $past(mode_q[5:4]) == 2'h2))
      else $error("reserved code flag");
   quad_store_a: assert property ((wr_mode && clk_en && pstrb[0]) |=>
      mode_q[5:4] == $past(pwdata[5:4])) else $error("quadrature write");
   clk_drv_a: assert property (clk_en |=>
      ctrl.sequencer_clock_driver_enables == $past(mode_q[2:1])) else $error("clk drv");
   clk_src_a: assert property (clk_en |=>
      ctrl.sequencer_clock_source == $past(mode_q[0])) else $error("clock source");
   reserved_zero_a: assert property ((chain_q & ~MASK_CHAIN) == 16'h0000
      && (sync_q & ~MASK_SYNC) == 16'h0000 && (mode_q & ~MASK_MODE) == 16'h0000)
      else $error("reserved bit set");
   ready_timing_a: assert property ((clk_en && psel && penable && state == ST_IDLE) ##1 clk_en
      |=> pready) else $error("pready late");


   // ****************************************************************
   // bus and storage checks
   // ****************************************************************
   // never an error
   no_error_a: assert property (!pslverr) else $error("error response raised");

   // ready is a single enabled cycle
   ready_pulse_a: assert property ((pready && clk_en) |=> !pready)
      else $error("pready held too long");

   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside a read");

   read_word_a: assert property ((state == ST_ACCESS && !pwrite && clk_en) |=>
      prdata == {16'h0000, $past(cur_word)}) else $error("read data wrong");

   unmapped_drop_a: assert property ((do_wr && clk_en && sel == SEL_NONE) |=>
      $stable(chain_q) && $stable(sync_q) && $stable(mode_q))
      else $error("unmapped write stored");

   // a low enable must hold the three words, ctrl, state and pready
   freeze_a: assert property (!clk_en |=> $stable(chain_q) && $stable(sync_q)
      && $stable(mode_q) && $stable(ctrl) && $stable(state) && $stable(pready))
      else $error("state moved while frozen");

   // sequencer stays one-hot
   state_onehot_a: assert property ($onehot(state)) else $error("state not one-hot");

   power_store_a: assert property ((wr_chain && clk_en && pstrb[0]) |=>
      chain_q[2:0] == $past(pwdata[2:0])) else $error("power bits write");

   pullup_store_a: assert property ((wr_chain && clk_en && pstrb[0]) |=>
      chain_q[6] == $past(pwdata[6])) else $error("pull-up write");

   loop_store_a: assert property ((wr_sync && clk_en && pstrb[1]) |=>
      sync_q[11] == $past(pwdata[11])) else $error("loop bit write");

   mux_store_a: assert property ((wr_sync && clk_en && pstrb[0]) |=>
      sync_q[5:0] == $past(pwdata[5:0])) else $error("mux write");

   poly_store_a: assert property ((wr_mode && clk_en && pstrb[1]) |=>
      mode_q[11:8] == $past(pwdata[11:8])) else $error("polyphase write");

   drvsel_store_a: assert property ((wr_mode && clk_en && pstrb[0]) |=>
      mode_q[7:6] == $past(pwdata[7:6])) else $error("driver select write");

   mode_low_store_a: assert property ((wr_mode && clk_en && pstrb[0]) |=>
      mode_q[2:0] == $past(pwdata[2:0])) else $error("clock enables write");

   path_store_a: assert property ((wr_chain && clk_en && pstrb[1]) |=>
      chain_q[14:12] == $past(pwdata[14:12])) else $error("path enables write");

   reset_words_a: assert property (first_cycle |-> chain_q == RST_CHAIN
      && sync_q == RST_SYNC && mode_q == RST_MODE)
      else $error("reset word wrong");

   reset_ctrl_a: assert property (first_cycle |->
      ctrl.osc_path_section_enables == RST_CHAIN[14:12]
      && ctrl.osc_mux_driver_setup == RST_SYNC[5:0] && !ctrl.sync_loop_close)
      else $error("control reset image wrong");

   write_seen_c: cover property (wr_chain && clk_en);
   reserved_seen_c: cover property (mode_reserved_code);
   read_seen_c:  cover property (pready && !pwrite && sel == SEL_MODE);
   div2_mode_c:  cover property (ctrl.osc_mux_driver_setup == MUX_DIV2);
   ext_clock_c:  cover property (ctrl.sequencer_clock_driver_select == SRC_EXT
      && ctrl.sequencer_clock_source);
endmodule

// File: verification/lo_path_mode_config_regs_test.sv
// Purpose: self-checking bench for the oscillator path configuration bank
// Assumes: APB slave answers after a few cycles; ctrl follows one enabled cycle later
// Notes:   fixed-seed random traffic; clk_en jitter stretches transfers at random
`timescale 1ns/1ps
module lo_path_mode_config_regs_test;
   import lo_cfg_pkg::*;
   logic              pclk;
   logic              presetn;
   logic              clk_en;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   lo_ctrl_t          ctrl;
   logic              mode_reserved_code;
   logic [15:0]       mdl [4];
   logic [31:0]       rd;
   logic              jitter;
   integer            seed;
   integer            bad_count;
   integer            cmp_count;
   integer            cycles;
   integer            i;
   integer            s;

   lo_path_mode_config_regs lo_path_mode_config_regs_i (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ctrl(ctrl), .mode_reserved_code(mode_reserved_code));

   // ****************************************************************
   // clock, clock-enable jitter and hang guard
   // ****************************************************************
   always #2 pclk = ~pclk;
   // jitter off while ctrl is compared, so the one-cycle lag is certain
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      clk_en <= jitter ? (($random(seed) & 3) != 0) : 1'b1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         tally_and_finish();
      end
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                      input logic [3:0] st, output logic [31:0] r);
      integer n;
      // a ready left standing by a frozen enable must clear before a new request
      while (pready === 1'b1) @(posedge pclk);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {$random(seed), d} >> 0;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n = n + 1;
      end while (pready !== 1'b1 && n < 100);
      if (n == 100)
         bad_count = bad_count + 1;
      r = prdata;
      chk("pslverr", {31'h0, pslverr}, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [15:0] wmask(input integer k);
      return (k == 0) ? 16'h7047 : (k == 1) ? 16'h0E3F : (k == 2) ? 16'h0FF7 : 16'h0000;
   endfunction

   task automatic wr_reg(input integer k, input logic [15:0] d, input logic [3:0] st);
      logic [15:0] bm;
      bm = {{8{st[1]}}, {8{st[0]}}};
      apb(1'b1, 12'h13C + 12'(4 * k), d, st, rd);
      mdl[k] = (mdl[k] & ~(bm & wmask(k))) | (d & bm & wmask(k));
   endtask

   task automatic rd_chk(input integer k);
      apb(1'b0, 12'h13C + 12'(4 * k), 16'h0, 4'h0, rd);
      chk("register read", rd, {16'h0, mdl[k]});
   endtask

   task automatic ctrl_chk();
      logic        resv;
      jitter = 0;
      repeat (3) @(posedge pclk);
      resv = (mdl[2][7:6] == 2'h1) || (mdl[2][7:6] == 2'h2) || (mdl[2][5:4] == 2'h2);
      chk("ctrl", {2'h0, ctrl}, {2'h0, mdl[0][14:12], mdl[0][6], mdl[0][2], mdl[0][1],
          mdl[0][0], mdl[1][11:9], mdl[1][5:0], mdl[2][11:4], mdl[2][2:0]});
      chk("reserved code flag", {31'h0, mode_reserved_code}, {31'h0, resv});
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      mdl = '{16'h7000, 16'h000A, 16'h0000, 16'h0000};
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
      seed = 44;
      bad_count = 0;
      cmp_count = 0;
      cycles = 0;
      jitter = 0;
      do_reset();
      // reset values, including the unmapped word after the bank
      for (i = 0; i < 4; i++) rd_chk(i);
      ctrl_chk();
      // all ones then all zeros: reserved bits stay clear
      for (i = 0; i < 3; i++) begin
         wr_reg(i, 16'hFFFF, 4'hF);
         rd_chk(i);
         ctrl_chk();
         wr_reg(i, 16'h0000, 4'hF);
         rd_chk(i);
      end
      // misaligned and unmapped writes are ignored
      apb(1'b1, 12'h13D, 16'hFFFF, 4'hF, rd);
      wr_reg(3, 16'hFFFF, 4'hF);
      for (i = 0; i < 4; i++) rd_chk(i);
      // every driver select and quadrature code, polyphase codes truncated to four bits
      for (i = 0; i < 16; i++) begin
         wr_reg(2, {4'h1, 4'h9 ^ i[3:0], i[3:0], 4'h7}, 4'hF);
         ctrl_chk();
      end
      wr_reg(2, 16'h1500, 4'hF);
      rd_chk(2);
      wr_reg(2, 16'h1900, 4'hF);
      rd_chk(2);
      wr_reg(1, 16'h0609, 4'hF);
      ctrl_chk();
      wr_reg(1, 16'h0E10, 4'hF);
      ctrl_chk();
      // random traffic with partial strobes and clock-enable stalls
      for (i = 0; i < 40; i++) begin
         jitter = 1;
         s = {$random(seed)} % 4;
         wr_reg(s, $random(seed), $random(seed));
         rd_chk(s);
         rd_chk({$random(seed)} % 3);
         ctrl_chk();
      end
      // second reset in mid-run restores every default
      do_reset();
      for (i = 0; i < 3; i++) rd_chk(i);
      ctrl_chk();
      tally_and_finish();
   end
endmodule
